/* File: core/pts_sequencer.sv */
`timescale 1ns/1ps
module pts_sequencer #(
	parameter bit HAS_DMA = 1'b1,
	parameter bit HAS_CFG = 1'b1,
	parameter int WIN_BITS = 20,
	parameter logic [31:0] WIN0_BASE = 32'h1000_0000,
	parameter logic [31:0] WIN1_BASE = 32'h2000_0000,
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// bus pins, inputs
	input wire pts_pkg::pts_pin_t pin_in,
	// bus pins, outputs and enables
	output logic [31:0] ad_out,
	output logic ad_oe,
	output logic [3:0] cbe_out,
	output logic cbe_oe,
	output logic frame_n_out,
	output logic frame_oe,
	output logic irdy_n_out,
	output logic irdy_oe,
	output logic trdy_n_out,
	output logic devsel_n_out,
	output logic stop_n_out,
	output logic tgt_oe,
	output logic req_n,
	// backend
	output logic xfer_begin_pulse,
	output logic wide_xfer_begin_pulse,
	output logic xfer_end_pulse,
	output logic read_cycle_flag,
	output logic write_cycle_flag,
	output logic window0_mem_hit,
	output logic window1_hit,
	output logic cfg_space_hit,
	input wire logic backend_source_ready,
	input wire logic backend_sink_ready,
	input wire logic [31:0] backend_rdata,
	output logic read_strobe,
	output logic write_strobe,
	output logic [31:0] backend_wdata,
	output logic [31:0] backend_addr
);
	import pts_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		pts_pin_t p1;
		pts_pin_t p2;
		pts_pin_t p3;
		pts_pin_t pin;
		pts_tg_t tst;
		pts_ms_t mst;
		logic begin_p;
		logic wide_p;
		logic end_p;
		logic rd;
		logic wr;
		logic w0;
		logic w1;
		logic cfg;
		logic [4:0] lat;
		logic rdv;
		logic [31:0] ad_q;
		logic [31:0] bus_addr;
		logic [31:0] loc_addr;
		logic [15:0] cnt;
		logic go;
		logic dir;
		logic aw;
		logic [7:0] aa;
		logic [31:0] hrd;
	} pts_st_t;
	pts_st_t s;
	pts_st_t next_s;
	pts_pin_t pin;
	pts_fifo_if #(.WIDTH(32)) fq ();
	logic in_tdata;
	logic in_mdata;
	logic trdy_t;
	logic t_done;
	logic irdy_m;
	logic m_done;
	logic rdstb_t;
	logic rdstb_m;
	logic hit;
	logic [31:0] rdmux;

	function automatic logic cmd_read(input logic [3:0] c);
		cmd_read = (c == PTS_CMD_MRD) || (c == PTS_CMD_IORD) || (c == PTS_CMD_CFGRD);
	endfunction

	function automatic logic in_win(input logic [31:0] a, input logic [31:0] base);
		in_win = (a >> WIN_BITS) == (base >> WIN_BITS);
	endfunction

	pts_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.q(fq.fifo)
	);

	// ************************************************************
	// handshakes
	// ************************************************************
	assign pin = s.pin;
	assign in_tdata = s.tst == PTS_TG_DATA;
	assign in_mdata = s.mst == PTS_MS_DATA;
	assign trdy_t = s.rd ? s.rdv : fq.in_ready;
	assign t_done = in_tdata & trdy_t & ~pin.irdy_n;
	assign rdstb_t = in_tdata & s.rd & backend_source_ready & ~pin.irdy_n;
	assign irdy_m = s.dir ? s.rdv : fq.in_ready;
	assign m_done = in_mdata & irdy_m & ~pin.trdy_n;
	assign rdstb_m = in_mdata & s.dir & backend_source_ready & (~s.rdv | m_done);
	assign read_strobe = rdstb_t | rdstb_m;
	assign fq.in_valid = (t_done & s.wr) | (m_done & ~s.dir);
	assign fq.in_data = pin.ad;
	assign fq.out_ready = backend_sink_ready;
	assign write_strobe = fq.out_valid & backend_sink_ready;
	assign backend_wdata = fq.out_data;
	assign backend_addr = s.loc_addr;

	// ************************************************************
	// bus outputs
	// ************************************************************
	assign tgt_oe = s.tst != PTS_TG_IDLE;
	assign trdy_n_out = !(in_tdata && trdy_t);
	assign devsel_n_out = !(in_tdata || s.tst == PTS_TG_STOP);
	assign stop_n_out = s.tst != PTS_TG_STOP;
	assign frame_oe = s.mst == PTS_MS_ADDR || in_mdata || s.mst == PTS_MS_TURN;
	assign frame_n_out = in_mdata ? (s.cnt == 16'h0001 && irdy_m) : s.mst != PTS_MS_ADDR;
	assign irdy_oe = frame_oe;
	assign irdy_n_out = !(in_mdata && irdy_m);
	assign req_n = !(HAS_DMA && (s.mst == PTS_MS_REQ || s.mst == PTS_MS_ADDR));
	assign ad_out = s.ad_q;
	assign ad_oe = s.mst == PTS_MS_ADDR || (in_mdata && s.dir) || (in_tdata && s.rd);
	assign cbe_oe = s.mst == PTS_MS_ADDR || in_mdata;
	assign cbe_out = (s.mst == PTS_MS_ADDR) ? (s.dir ? PTS_CMD_MWR : PTS_CMD_MRD) : PTS_BE_ALL;
	assign xfer_begin_pulse = s.begin_p;
	assign wide_xfer_begin_pulse = s.wide_p;
	assign xfer_end_pulse = s.end_p;
	assign read_cycle_flag = s.rd;
	assign write_cycle_flag = s.wr;
	assign window0_mem_hit = s.w0;
	assign window1_hit = s.w1;
	assign cfg_space_hit = s.cfg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrd;

	always_comb begin
		case (haddr[7:0])
			PTS_REG_BUS_ADDR: rdmux = s.bus_addr;
			PTS_REG_LOC_ADDR: rdmux = s.loc_addr;
			PTS_REG_CTRL: rdmux = {s.cnt, 14'h0000, s.dir, s.go};
			PTS_REG_STATUS: rdmux = {26'h0000000, s.tst, s.mst};
			default: rdmux = PTS_RST_WORD;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s = s;
		// three stages; a bit moves on once stages two and three agree
		next_s.p1 = pin_in;
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;
		next_s.pin = (s.p2 & s.p3) | (s.pin & (s.p2 ^ s.p3));
		next_s.begin_p = 1'b0;
		next_s.wide_p = 1'b0;
		next_s.end_p = 1'b0;
		hit = 1'b0;
		case (s.tst)
			PTS_TG_IDLE: begin
				// a new frame is seen as frame low with irdy still high
				if (s.mst == PTS_MS_IDLE && !pin.frame_n && pin.irdy_n) begin
					next_s.w0 = pin.cbe[3:1] == PTS_CMD_MRD[3:1] && in_win(pin.ad, WIN0_BASE);
					next_s.w1 = (pin.cbe[3:1] == PTS_CMD_MRD[3:1] || pin.cbe[3:1] == PTS_CMD_IORD[3:1])
						&& in_win(pin.ad, WIN1_BASE);
					next_s.cfg = HAS_CFG && pin.idsel && pin.cbe[3:1] == PTS_CMD_CFGRD[3:1];
					hit = next_s.w0 | next_s.w1 | next_s.cfg;
					next_s.rd = hit & cmd_read(pin.cbe);
					next_s.wr = hit & ~cmd_read(pin.cbe);
					next_s.begin_p = hit;
					next_s.wide_p = hit & ~pin.req64_n;
					next_s.lat = '0;
					next_s.rdv = 1'b0;
					if (hit) begin
						next_s.tst = PTS_TG_DATA;
					end
				end
			end
			PTS_TG_DATA: begin
				next_s.rdv = rdstb_t;
				if (s.rd && !s.rdv) begin
					next_s.lat = s.lat + 5'h01;
				end else begin
					next_s.lat = '0;
				end
				if (t_done && pin.frame_n) begin
					next_s.tst = PTS_TG_TURN;
					next_s.end_p = 1'b1;
				end else if (s.rd && !s.rdv && !rdstb_t && s.lat == PTS_LAT_LIMIT_CLK - 5'h01) begin
					next_s.tst = PTS_TG_STOP;
				end
			end
			PTS_TG_STOP: begin
				if (pin.frame_n) begin
					next_s.tst = PTS_TG_TURN;
					next_s.end_p = 1'b1;
				end
			end
			PTS_TG_TURN: begin
				next_s.tst = PTS_TG_IDLE;
				{next_s.rd, next_s.wr, next_s.w0, next_s.w1, next_s.cfg} = '0;
			end
			default: next_s.tst = PTS_TG_IDLE;
		endcase
		// dma machine
		case (s.mst)
			PTS_MS_IDLE: begin
				if (HAS_DMA && s.go && s.cnt != PTS_RST_CNT) begin
					next_s.mst = PTS_MS_REQ;
				end
			end
			PTS_MS_REQ: begin
				if (!pin.gnt_n && pin.frame_n && pin.irdy_n && s.tst == PTS_TG_IDLE) begin
					next_s.mst = PTS_MS_ADDR;
				end
			end
			PTS_MS_ADDR: begin
				next_s.mst = PTS_MS_DATA;
				next_s.rdv = 1'b0;
			end
			PTS_MS_DATA: begin
				next_s.rdv = rdstb_m | (s.rdv & ~m_done);
				if (m_done) begin
					next_s.cnt = s.cnt - 16'h0001;
					next_s.bus_addr = s.bus_addr + 32'h0000_0004;
				end
				if ((m_done && s.cnt == 16'h0001) || !pin.stop_n) begin
					next_s.mst = PTS_MS_TURN;
				end
			end
			PTS_MS_TURN: begin
				next_s.mst = PTS_MS_IDLE;
				next_s.go = 1'b0;
				next_s.rdv = 1'b0;
			end
			default: next_s.mst = PTS_MS_IDLE;
		endcase
		if (next_s.mst == PTS_MS_ADDR) begin
			next_s.ad_q = s.bus_addr;
		end else if (read_strobe) begin
			next_s.ad_q = backend_rdata;
		end
		if (s.mst != PTS_MS_IDLE && (read_strobe || write_strobe)) begin
			next_s.loc_addr = s.loc_addr + 32'h0000_0001;
		end
		// register bus: address phase latched, write taken in data phase
		next_s.aw = hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
		if (hsel && htrans[1] && hready) begin
			next_s.aa = haddr[7:0];
			next_s.hrd = rdmux;
		end
		if (s.aw && s.mst == PTS_MS_IDLE) begin
			case (s.aa)
				PTS_REG_BUS_ADDR: next_s.bus_addr = hwdata;
				PTS_REG_LOC_ADDR: next_s.loc_addr = hwdata;
				PTS_REG_CTRL: begin
					next_s.go = hwdata[PTS_CTRL_GO];
					next_s.dir = hwdata[PTS_CTRL_DIR];
					next_s.cnt = hwdata[PTS_CTRL_CNT_LSB +: 16];
				end
				default: next_s.go = s.go;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{PTS_PIN_RST, PTS_PIN_RST, PTS_PIN_RST, PTS_PIN_RST, PTS_TG_IDLE, PTS_MS_IDLE,
				1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, PTS_RST_WORD,
				PTS_RST_WORD, PTS_RST_WORD, PTS_RST_CNT, 1'b0, 1'b0, 1'b0, 8'h00,
				PTS_RST_WORD};
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	begin_flags_a: assert property (
		xfer_begin_pulse |-> (read_cycle_flag ^ write_cycle_flag)
			&& (window0_mem_hit || window1_hit || cfg_space_hit) && s.tst == PTS_TG_DATA)
		else $error("begin pulse without decoded cycle");
	flags_hold_a: assert property (
		s.tst == PTS_TG_DATA && $past(s.tst) == PTS_TG_DATA |->
			$stable({read_cycle_flag, write_cycle_flag, window0_mem_hit, window1_hit,
				cfg_space_hit}))
		else $error("cycle flags moved during transaction");
	master_start_a: assert property (
		s.mst == PTS_MS_ADDR |-> !frame_n_out && frame_oe && $past(s.mst) == PTS_MS_REQ
			&& !$past(pin.gnt_n))
		else $error("frame driven without grant");
	burst_end_a: assert property (
		m_done && s.cnt == 16'h0001 |-> frame_n_out ##1 s.mst == PTS_MS_TURN
			##1 s.mst == PTS_MS_IDLE && req_n)
		else $error("burst not ended on count");
	no_request_a: assert property (
		!req_n |-> HAS_DMA && s.go && s.cnt != PTS_RST_CNT)
		else $error("bus requested without an enabled burst");
	target_wait_a: assert property (
		in_tdata && s.wr && !fq.in_ready |-> trdy_n_out)
		else $error("trdy asserted while buffer full");
	strobe_gate_a: assert property (
		read_strobe && in_tdata |-> backend_source_ready && !pin.irdy_n)
		else $error("read strobe without both ready");
	strobe_data_a: assert property (
		read_strobe && s.mst != PTS_MS_REQ |=> ad_out == $past(backend_rdata))
		else $error("strobed word not captured");
	disconnect_a: assert property (
		s.tst == PTS_TG_DATA && s.rd && !s.rdv && !rdstb_t && s.lat == PTS_LAT_LIMIT_CLK - 5'h01
			|=> s.tst == PTS_TG_STOP && !stop_n_out && trdy_n_out)
		else $error("no disconnect after latency limit");
	end_release_a: assert property (
		xfer_end_pulse |-> s.tst == PTS_TG_TURN && devsel_n_out && trdy_n_out && stop_n_out
			##1 !tgt_oe)
		else $error("target signals not released after end");
	sole_driver_a: assert property (
		tgt_oe |-> s.tst != PTS_TG_IDLE && !(ad_oe && s.mst == PTS_MS_ADDR))
		else $error("target signals driven while idle");
endmodule // pts_sequencer

/* File: core/pts_pkg.sv */
package pts_pkg;
	// ************************************************************
	// register map, byte addresses on the register bus
	// ************************************************************
	localparam logic [7:0] PTS_REG_BUS_ADDR = 8'h00;
	localparam logic [7:0] PTS_REG_LOC_ADDR = 8'h04;
	localparam logic [7:0] PTS_REG_CTRL = 8'h08;
	localparam logic [7:0] PTS_REG_STATUS = 8'h0C;
	localparam int PTS_CTRL_GO = 0;
	localparam int PTS_CTRL_DIR = 1;
	localparam int PTS_CTRL_CNT_LSB = 16;
	localparam logic [31:0] PTS_RST_WORD = 32'h0000_0000;
	localparam logic [15:0] PTS_RST_CNT = 16'h0000;
	// ************************************************************
	// bus commands and timing
	// ************************************************************
	localparam logic [3:0] PTS_CMD_IORD = 4'h2;
	localparam logic [3:0] PTS_CMD_IOWR = 4'h3;
	localparam logic [3:0] PTS_CMD_MRD = 4'h6;
	localparam logic [3:0] PTS_CMD_MWR = 4'h7;
	localparam logic [3:0] PTS_CMD_CFGRD = 4'hA;
	localparam logic [3:0] PTS_CMD_CFGWR = 4'hB;
	localparam logic [3:0] PTS_BE_ALL = 4'h0;
	localparam logic [4:0] PTS_LAT_LIMIT_CLK = 5'h10;
	// ************************************************************
	// states and pin bundle
	// ************************************************************
	typedef enum logic [2:0] {
		PTS_TG_IDLE = 3'h0,
		PTS_TG_DATA = 3'h1,
		PTS_TG_STOP = 3'h3,
		PTS_TG_TURN = 3'h2
	} pts_tg_t;
	typedef enum logic [2:0] {
		PTS_MS_IDLE = 3'h0,
		PTS_MS_REQ = 3'h1,
		PTS_MS_ADDR = 3'h3,
		PTS_MS_DATA = 3'h2,
		PTS_MS_TURN = 3'h6
	} pts_ms_t;
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic req64_n;
		logic idsel;
		logic gnt_n;
		logic stop_n;
		logic devsel_n;
		logic trdy_n;
		logic irdy_n;
		logic frame_n;
	} pts_pin_t;
	localparam pts_pin_t PTS_PIN_RST = '{32'h0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, 1'b1};
endpackage

/* File: core/pts_fifo_if.sv */
`timescale 1ns/1ps
interface pts_fifo_if #(parameter int WIDTH = 32);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface // pts_fifo_if

/* File: core/pts_fifo.sv */
`timescale 1ns/1ps
module pts_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// both sides
	pts_fifo_if.fifo q
);
	import pts_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} pts_fifo_st_t;
	pts_fifo_st_t s;
	pts_fifo_st_t next_s;
	logic push;
	logic pop;

	assign q.in_ready = s.cnt != (AW+1)'(DEPTH);
	assign q.out_valid = s.cnt != '0;
	assign q.out_data = s.mem[s.rp];
	assign push = q.in_valid & q.in_ready;
	assign pop = q.out_valid & q.out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = q.in_data;
			next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	count_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // pts_fifo

/* File: bench/pts_far_end.sv */
`timescale 1ns/1ps
// ************************************************************
// far side: bus host, arbiter, other bus target and backend
// ************************************************************
module pts_far_end (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// device drive
	input wire logic [31:0] ad_out,
	input wire logic ad_oe,
	input wire logic [3:0] cbe_out,
	input wire logic cbe_oe,
	input wire logic frame_n_out,
	input wire logic frame_oe,
	input wire logic irdy_n_out,
	input wire logic irdy_oe,
	input wire logic trdy_n_out,
	input wire logic devsel_n_out,
	input wire logic stop_n_out,
	input wire logic tgt_oe,
	input wire logic req_n,
	input wire logic read_strobe,
	// resolved pins and backend
	output pts_pkg::pts_pin_t pin_in,
	output logic backend_source_ready,
	output logic backend_sink_ready,
	output logic [31:0] backend_rdata
);
	import pts_pkg::*;
	logic h_frame_n = 1'b1;
	logic h_irdy_n = 1'b1;
	logic h_drv = 1'b0;
	logic h_idsel = 1'b0;
	logic h_req64_n = 1'b1;
	logic [31:0] h_ad = 32'h0;
	logic [3:0] h_cbe = 4'h0;
	logic src_en = 1'b1;
	logic slow = 1'b0;
	logic [31:0] rd_word = 32'h0;
	logic [15:0] cyc;
	logic [1:0] rnd;
	logic gnt_n;
	logic mst_live;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc <= 16'h0;
			rnd <= 2'h3;
			gnt_n <= 1'b1;
		end else begin
			cyc <= cyc + 16'h1;
			rnd <= 2'($urandom);
			gnt_n <= req_n;
		end
	end
	// a slow backend drops readiness at random
	assign backend_source_ready = src_en & (~slow | rnd[0]);
	assign backend_sink_ready = ~slow | rnd[1];
	// word stands only where it is strobed, so a late sample shows up
	assign backend_rdata = read_strobe ? rd_word : ~rd_word ^ {cyc, cyc};
	// plays the target whenever the device masters the bus
	assign mst_live = (frame_oe & ~frame_n_out) | (irdy_oe & ~irdy_n_out);
	// handshakes have pull-ups; undriven ad and cbe change every cycle
	assign pin_in = '{ad_oe ? ad_out : (h_drv ? h_ad : {cyc, ~cyc}),
		cbe_oe ? cbe_out : (h_drv ? h_cbe : cyc[3:0]), h_req64_n, h_idsel, gnt_n,
		tgt_oe ? stop_n_out : 1'b1, tgt_oe ? devsel_n_out : ~mst_live,
		tgt_oe ? trdy_n_out : ~mst_live, irdy_oe ? irdy_n_out : h_irdy_n,
		frame_oe ? frame_n_out : h_frame_n};
endmodule // pts_far_end

/* File: bench/pci_target_master_sequencer_test.sv */
`timescale 1ns/1ps
module pci_target_master_sequencer_test;
	import pts_pkg::*;
	localparam logic [31:0] W0 = 32'h1000_0000;
	localparam logic [31:0] W1 = 32'h2000_0000;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, ad_out, backend_rdata, backend_wdata, backend_addr;
	logic [3:0] cbe_out;
	logic ad_oe, cbe_oe, frame_n_out, frame_oe, irdy_n_out, irdy_oe, trdy_n_out;
	logic devsel_n_out, stop_n_out, tgt_oe, req_n, read_strobe, write_strobe;
	logic xfer_begin_pulse, wide_xfer_begin_pulse, xfer_end_pulse, read_cycle_flag;
	logic write_cycle_flag, window0_mem_hit, window1_hit, cfg_space_hit;
	logic backend_source_ready, backend_sink_ready;
	pts_pin_t pin_in;
	int num_errors = 0;
	int samples_checked = 0;
	int ends = 0, stops = 0, claims = 0, rstb = 0, dma_words = 0, irdy_seen = 0, last_seen = 0;
	logic rd_pend = 1'b0;
	logic dma_on = 1'b0;
	logic [5:0] held, cur;
	logic [5:0] q_flag [$];
	logic [31:0] q_reg [$], q_rd [$], q_wr [$];
	logic [3:0] cmds [6] = '{PTS_CMD_MRD, PTS_CMD_MWR, PTS_CMD_IORD, PTS_CMD_IOWR,
		PTS_CMD_CFGRD, PTS_CMD_CFGWR};
	assign hready = hreadyout;
	assign cur = {read_cycle_flag, write_cycle_flag, window0_mem_hit, window1_hit, cfg_space_hit,
		wide_xfer_begin_pulse};
	pts_sequencer #(.WIN0_BASE(W0), .WIN1_BASE(W1)) DUT (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pin_in,
		.ad_out, .ad_oe, .cbe_out, .cbe_oe, .frame_n_out, .frame_oe, .irdy_n_out, .irdy_oe,
		.trdy_n_out, .devsel_n_out, .stop_n_out, .tgt_oe, .req_n, .xfer_begin_pulse,
		.wide_xfer_begin_pulse, .xfer_end_pulse, .read_cycle_flag, .write_cycle_flag,
		.window0_mem_hit, .window1_hit, .cfg_space_hit, .backend_source_ready,
		.backend_sink_ready, .backend_rdata, .read_strobe, .write_strobe, .backend_wdata,
		.backend_addr);
	pts_far_end FAR (.hclk, .hresetn, .ad_out, .ad_oe, .cbe_out, .cbe_oe, .frame_n_out,
		.frame_oe, .irdy_n_out, .irdy_oe, .trdy_n_out, .devsel_n_out, .stop_n_out, .tgt_oe,
		.req_n, .read_strobe, .pin_in, .backend_source_ready, .backend_sink_ready,
		.backend_rdata);
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// ************************************************************
	// compare, report
	// ************************************************************
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_flags(input string what, input logic [5:0] exp, input logic [5:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic timed_out(input string what);
		num_errors++;
		$display("FAIL wait for %s expected done seen timeout", what);
		complete_run();
	endtask
	// ************************************************************
	// drivers: register bus master and bus host
	// ************************************************************
	task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] data);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, off};
		hwrite <= wr;
		for (n = 0; n < 50 && !(n > 0 && hready); n++) @(posedge hclk);
		if (n == 50) timed_out("register address");
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= data;
		for (n = 0; n < 50 && !(n > 0 && hready); n++) @(posedge hclk);
		if (n == 50) timed_out("register bus");
		check_word("response", 32'h0, 32'(hresp));
	endtask
	task automatic ahb_rd(input logic [7:0] off, input logic [31:0] exp);
		q_reg.push_back(exp);
		ahb(1'b0, off, $urandom);
	endtask
	task automatic host_access(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
			input logic wide, input logic [5:0] flags);
		logic [31:0] word;
		int n, e0;
		word = $urandom;
		e0 = ends;
		if (flags != 6'h0) q_flag.push_back(flags);
		if (!cmd[0] && flags != 6'h0 && FAR.src_en) q_rd.push_back(word);
		if (cmd[0] && flags != 6'h0) q_wr.push_back(word);
		FAR.rd_word <= word;
		FAR.h_drv <= 1'b1;
		FAR.h_frame_n <= 1'b0;
		FAR.h_ad <= addr;
		FAR.h_cbe <= cmd;
		FAR.h_idsel <= sel;
		FAR.h_req64_n <= !wide;
		repeat (4) @(posedge hclk);
		// one data phase, so frame rises as irdy falls
		FAR.h_frame_n <= 1'b1;
		FAR.h_irdy_n <= 1'b0;
		FAR.h_cbe <= PTS_BE_ALL;
		FAR.h_drv <= cmd[0];
		FAR.h_ad <= word;
		FAR.h_idsel <= 1'b0;
		FAR.h_req64_n <= 1'b1;
		@(posedge hclk);
		if (flags == 6'h0) begin
			// host gives up on its own after a fixed time
			repeat (20) @(posedge hclk);
		end else begin
			for (n = 0; n < 100 && !(tgt_oe && !(trdy_n_out && stop_n_out)); n++) @(posedge hclk);
			if (n == 100) timed_out("target answer");
			check_word("devsel", 32'h0, 32'(devsel_n_out));
		end
		FAR.h_irdy_n <= 1'b1;
		FAR.h_drv <= 1'b0;
		for (n = 0; n < 50 && flags != 6'h0 && ends == e0; n++) @(posedge hclk);
		if (n == 50) timed_out("end pulse");
		repeat (6) @(posedge hclk);
	endtask
	// ************************************************************
	// monitor: oldest note against each result
	// ************************************************************
	always @(posedge hclk) begin
		if (rd_pend && hready) check_word("register", q_reg.size() ? q_reg.pop_front() : 'x, hrdata);
		rd_pend = hresetn && hsel && htrans[1] && !hwrite && hready;
		if (xfer_begin_pulse) begin
			check_flags("begin flags", q_flag.size() ? q_flag.pop_front() : 'x, cur);
			held = cur;
		end
		if (xfer_end_pulse) begin
			check_flags("flags at end", {held[5:1], 1'b0}, {cur[5:1], 1'b0});
			ends++;
		end
		if (tgt_oe && !trdy_n_out && !pin_in.irdy_n && q_rd.size()) begin
			check_word("read word", q_rd.pop_front(), ad_out);
		end
		if (write_strobe && !dma_on) begin
			check_word("write word", q_wr.size() ? q_wr.pop_front() : 'x, backend_wdata);
		end
		stops += int'(tgt_oe && !stop_n_out);
		claims += int'(tgt_oe);
		rstb += int'(read_strobe);
		dma_words += int'(dma_on && write_strobe);
		irdy_seen += int'(irdy_oe && !irdy_n_out);
		last_seen += int'(frame_oe && frame_n_out && irdy_oe && !irdy_n_out);
	end
	initial begin
		int i, p, n, s0, c0;
		logic [31:0] a;
		logic [31:0] ba;
		logic w;
		void'($urandom(25));
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 5; i++) ahb_rd(8'(i * 4), PTS_RST_WORD);
		a = $urandom;
		ahb(1'b1, PTS_REG_BUS_ADDR, a);
		ahb(1'b1, PTS_REG_LOC_ADDR, ~a);
		ahb(1'b1, 8'h10, a);
		ahb_rd(PTS_REG_BUS_ADDR, a);
		ahb_rd(PTS_REG_LOC_ADDR, ~a);
		ahb_rd(8'h10, 32'h0);
		for (p = 0; p < 2; p++) begin
			FAR.slow <= p[0];
			for (i = 0; i < 6; i++) begin
				a = (i < 2 ? W0 : (i < 4 ? W1 : 32'h0)) | ($urandom & 32'h000F_FFFC);
				w = 1'($urandom);
				host_access(cmds[i], a, i >= 4, w, {!cmds[i][0], cmds[i][0], i < 2, i == 2 || i == 3,
					i >= 4, w});
			end
		end
		c0 = claims;
		host_access(PTS_CMD_MRD, 32'h3000_0000, 1'b0, 1'b0, 6'h0);
		check_word("claims on a miss", 32'(c0), 32'(claims));
		FAR.slow <= 1'b0;
		FAR.src_en <= 1'b0;
		@(posedge hclk);
		s0 = stops;
		c0 = rstb;
		host_access(PTS_CMD_MRD, W0 | 32'h40, 1'b0, 1'b0, 6'b101000);
		check_word("disconnect", 32'h1, 32'(stops != s0));
		check_word("read strobes", 32'(c0), 32'(rstb));
		FAR.src_en <= 1'b1;
		dma_on = 1'b1;
		ba = 32'h3000_0000 | ($urandom & 32'h0000_0FFC);
		a = $urandom;
		ahb(1'b1, PTS_REG_LOC_ADDR, a);
		ahb(1'b1, PTS_REG_BUS_ADDR, ba);
		ahb(1'b1, PTS_REG_CTRL, 32'h0002_0001);
		for (n = 0; n < 50 && req_n; n++) @(posedge hclk);
		if (n == 50) timed_out("bus request");
		for (n = 0; n < 50 && !(frame_oe && !frame_n_out); n++) @(posedge hclk);
		if (n == 50) timed_out("master frame");
		check_word("grant at frame", 32'h0, 32'(pin_in.gnt_n));
		check_word("start address", ba, ad_out);
		check_word("command", 32'(PTS_CMD_MRD), 32'(cbe_out));
		for (n = 0; n < 200 && !(req_n && !frame_oe && !irdy_oe); n++) @(posedge hclk);
		if (n == 200) timed_out("burst end");
		repeat (4) @(posedge hclk);
		check_word("burst words", 32'h2, 32'(dma_words));
		check_word("local address", a + 32'h0000_0002, backend_addr);
		check_word("irdy driven", 32'h1, 32'(irdy_seen != 0));
		check_word("frame up on last phase", 32'h1, 32'(last_seen != 0));
		ahb_rd(PTS_REG_STATUS, 32'h0);
		ahb(1'b1, PTS_REG_CTRL, 32'h0008_0001);
		for (n = 0; n < 50 && !(frame_oe && !frame_n_out); n++) @(posedge hclk);
		if (n == 50) timed_out("second burst");
		hresetn <= 1'b0;
		@(posedge hclk);
		check_word("outputs in reset", 32'h1, 32'({ad_oe, cbe_oe, frame_oe, irdy_oe, tgt_oe, req_n}));
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		complete_run();
	end
endmodule // pci_target_master_sequencer_test
